// ### inc/psd_pkg.sv
package psd_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [9:0] IDX_MULT = 10'h034;
    localparam logic [9:0] IDX_REFERENCE_DIVISOR = 10'h035;
    localparam logic [9:0] IDX_POST = 10'h036;
    localparam logic [9:0] IDX_FLAGS = 10'h037;
    localparam logic [9:0] IDX_CLKS = 10'h039;
    localparam logic [9:0] IDX_OSC = 10'h2fa;
    localparam logic [9:0] IDX_GUARD = 10'h2fb;

    // ------------------------------------------------------------
    // field positions and masks
    // ------------------------------------------------------------
    localparam int unsigned MULT_DIV_LSB = 0;
    localparam int unsigned MULT_GAIN_LSB = 6;
    localparam int unsigned REF_DIV_LSB = 0;
    localparam int unsigned REF_FILT_LSB = 6;
    localparam int unsigned FLG_CHANGE_BIT = 4;
    localparam int unsigned FLG_SETTLED_BIT = 3;
    localparam int unsigned FLG_QUAL_BIT = 0;
    localparam int unsigned CLKS_BUS_FROM_PLL_SELECT_BIT = 7;
    localparam int unsigned OSC_ENABLE_BIT = 7;
    localparam int unsigned GUARD_BIT = 0;
    localparam logic [7:0] REFERENCE_DIVISOR_MASK = 8'hcf;
    localparam logic [7:0] POST_MASK = 8'h1f;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] MULT_RST = 8'h5f;
    localparam logic [7:0] REFERENCE_DIVISOR_RST = 8'h00;
    localparam logic [7:0] POST_RST = 8'h03;
    localparam logic CLKS_BUS_FROM_PLL_SELECT_RST = 1'b1;
    localparam logic OSC_ENABLE_RST = 1'b0;
    localparam logic GUARD_RST = 1'b0;

    // ------------------------------------------------------------
    // frequency derivation and timing
    // ------------------------------------------------------------
    localparam logic [31:0] IRC_KHZ = 32'h0000_03e8;
    localparam logic [1:0] FIXED_FILTER = 2'h0;
    localparam int unsigned UNLOCK_SHIFT = 2;
    localparam int unsigned BUS_SHIFT = 1;
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned LOCK_TIME_US = 150;
    localparam int unsigned QUAL_TIME_US = 50;
    localparam int unsigned LOCK_CYCLES = LOCK_TIME_US * CLK_MHZ;
    localparam int unsigned QUAL_CYCLES = QUAL_TIME_US * CLK_MHZ;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } psd_apb_req_t;

    typedef struct packed {
        logic [31:0] ref_khz;
        logic [31:0] vco_khz;
        logic [31:0] pll_khz;
        logic [31:0] bus_khz;
    } psd_freq_t;

    function automatic logic psd_hit(input logic [11:0] addr,
                                     input logic [9:0] idx);
        return addr == {idx, 2'b00};
    endfunction

endpackage

// ### hdl/psd_settle_timer.sv
`timescale 1ns/10ps
module psd_settle_timer #(
    parameter int unsigned CYCLES = 16
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic reset_in,
    // control
    input wire logic restart_in,
    input wire logic enable_in,
    // status
    output logic done_out
);
    localparam int unsigned CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic done;
    } psd_timer_state_t;

    psd_timer_state_t st_r;
    psd_timer_state_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (restart_in || !enable_in) begin
            st_nxt.cnt = '0;
            st_nxt.done = 1'b0;
        end else if (!st_r.done) begin
            st_nxt.cnt = st_r.cnt + CW'(1);
            st_nxt.done = (st_r.cnt == LAST);
        end
    end

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign done_out = st_r.done;
endmodule

// ### hdl/psd_freq_calc.sv
`timescale 1ns/10ps
module psd_freq_calc (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic reset_in,
    // configuration
    input wire logic [31:0] osc_freq_khz_in,
    input wire logic osc_enable_in,
    input wire logic [3:0] ref_div_in,
    input wire logic [5:0] mult_in,
    input wire logic [4:0] post_div_in,
    input wire logic settled_in,
    input wire logic pll_sel_in,
    // derived frequencies
    output psd_pkg::psd_freq_t freq_out
);
    psd_pkg::psd_freq_t st_r;
    psd_pkg::psd_freq_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (osc_enable_in) begin
            st_nxt.ref_khz = osc_freq_khz_in /
                (32'(ref_div_in) + 32'h0000_0001);
        end else begin
            st_nxt.ref_khz = psd_pkg::IRC_KHZ;
        end
        st_nxt.vco_khz = 32'((st_nxt.ref_khz *
            (32'(mult_in) + 32'h0000_0001)) << 1);
        if (settled_in) begin
            st_nxt.pll_khz = st_nxt.vco_khz /
                (32'(post_div_in) + 32'h0000_0001);
        end else begin
            st_nxt.pll_khz = st_nxt.vco_khz >> psd_pkg::UNLOCK_SHIFT;
        end
        if (pll_sel_in) begin
            st_nxt.bus_khz = st_nxt.pll_khz >> psd_pkg::BUS_SHIFT;
        end else begin
            st_nxt.bus_khz = osc_freq_khz_in;
        end
    end

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign freq_out = st_r;
endmodule

// ### hdl/psd_pll_synth_divider_control.sv
// Added by the designer: the APB slave port.
`timescale 1ns/10ps
module psd_pll_synth_divider_control #(
    parameter int unsigned LOCK_CYCLES = psd_pkg::LOCK_CYCLES,
    parameter int unsigned QUAL_CYCLES = psd_pkg::QUAL_CYCLES
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic reset_in,
    // apb slave
    input wire psd_pkg::psd_apb_req_t apb_req_in,
    output logic [31:0] apb_prdata_out,
    output logic apb_pready_out,
    output logic apb_pslverr_out,
    // oscillator measurement, same clock domain
    input wire logic [31:0] osc_freq_khz_in,
    // synthesizer settings
    output logic [5:0] feedback_multiplier_out,
    output logic [1:0] vco_gain_range_out,
    output logic [3:0] reference_divisor_out,
    output logic [1:0] loop_filter_range_out,
    output logic [4:0] output_divisor_out,
    output logic external_osc_enable_out,
    output logic bus_from_pll_select_out,
    // status
    output logic pll_settled_out,
    output logic oscillator_qualified_out,
    output logic settle_change_flag_out,
    // derived frequencies in kHz
    output psd_pkg::psd_freq_t freq_out
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] mult;
        logic [7:0] reference_divisor;
        logic [7:0] post;
        logic pll_sel;
        logic osc_en;
        logic guard;
        logic chg_flag;
        logic settled_prev;
        logic [31:0] prdata;
    } psd_ctrl_state_t;

    psd_ctrl_state_t st_r;
    psd_ctrl_state_t st_nxt;

    logic settled;
    logic qualified;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic setup_phase;
    logic access_phase;
    logic wr_access;
    logic mapped;
    logic hit_mult;
    logic hit_reference_divisor;
    logic hit_post;
    logic hit_flags;
    logic hit_clks;
    logic hit_osc;
    logic hit_guard;
    logic guard_ok;
    logic mult_wr;
    logic reference_divisor_wr;
    logic post_wr;
    logic clks_wr;
    logic osc_wr;
    logic guard_wr;
    logic flags_wr;
    logic osc_toggle;
    logic lock_restart;
    logic qual_restart;
    logic [7:0] rd_byte;
    logic [7:0] wdata;

    assign setup_phase = apb_req_in.psel && !apb_req_in.penable;
    assign access_phase = apb_req_in.psel && apb_req_in.penable;
    assign wr_access = access_phase && apb_req_in.pwrite;
    assign wdata = apb_req_in.pwdata[7:0];

    always_comb begin
        hit_mult = 1'b0;
        hit_reference_divisor = 1'b0;
        hit_post = 1'b0;
        hit_flags = 1'b0;
        hit_clks = 1'b0;
        hit_osc = 1'b0;
        hit_guard = 1'b0;
        if (psd_pkg::psd_hit(apb_req_in.paddr, psd_pkg::IDX_MULT)) begin
            hit_mult = 1'b1;
        end else if (psd_pkg::psd_hit(apb_req_in.paddr,
                                      psd_pkg::IDX_REFERENCE_DIVISOR)) begin
            hit_reference_divisor = 1'b1;
        end else if (psd_pkg::psd_hit(apb_req_in.paddr,
                                      psd_pkg::IDX_POST)) begin
            hit_post = 1'b1;
        end else if (psd_pkg::psd_hit(apb_req_in.paddr,
                                      psd_pkg::IDX_FLAGS)) begin
            hit_flags = 1'b1;
        end else if (psd_pkg::psd_hit(apb_req_in.paddr,
                                      psd_pkg::IDX_CLKS)) begin
            hit_clks = 1'b1;
        end else if (psd_pkg::psd_hit(apb_req_in.paddr,
                                      psd_pkg::IDX_OSC)) begin
            hit_osc = 1'b1;
        end else if (psd_pkg::psd_hit(apb_req_in.paddr,
                                      psd_pkg::IDX_GUARD)) begin
            hit_guard = 1'b1;
        end
    end

    assign mapped = hit_mult || hit_reference_divisor || hit_post || hit_flags ||
                    hit_clks || hit_osc || hit_guard;

    // ------------------------------------------------------------
    // write qualification
    // ------------------------------------------------------------
    // refused writes complete normally without an error response, so
    // software cannot tell from the bus that a write was dropped
    assign guard_ok = !st_r.guard && st_r.pll_sel;
    assign mult_wr = wr_access && hit_mult && guard_ok;
    assign reference_divisor_wr = wr_access && hit_reference_divisor && guard_ok;
    assign post_wr = wr_access && hit_post && st_r.pll_sel;
    assign clks_wr = wr_access && hit_clks && !st_r.guard;
    assign osc_wr = wr_access && hit_osc && !st_r.guard;
    assign guard_wr = wr_access && hit_guard;
    assign flags_wr = wr_access && hit_flags;

    assign osc_toggle = osc_wr &&
                        (wdata[psd_pkg::OSC_ENABLE_BIT] != st_r.osc_en);

    // a new reference also means the loop must settle again
    assign lock_restart = mult_wr || reference_divisor_wr || osc_toggle;
    assign qual_restart = mult_wr || reference_divisor_wr;

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    always_comb begin
        rd_byte = 8'h00;
        if (hit_mult) begin
            rd_byte = st_r.mult;
        end else if (hit_reference_divisor) begin
            rd_byte = st_r.reference_divisor & psd_pkg::REFERENCE_DIVISOR_MASK;
        end else if (hit_post) begin
            rd_byte = st_r.post & psd_pkg::POST_MASK;
        end else if (hit_flags) begin
            rd_byte[psd_pkg::FLG_CHANGE_BIT] = st_r.chg_flag;
            rd_byte[psd_pkg::FLG_SETTLED_BIT] = settled;
            rd_byte[psd_pkg::FLG_QUAL_BIT] = qualified;
        end else if (hit_clks) begin
            rd_byte[psd_pkg::CLKS_BUS_FROM_PLL_SELECT_BIT] = st_r.pll_sel;
        end else if (hit_osc) begin
            rd_byte[psd_pkg::OSC_ENABLE_BIT] = st_r.osc_en;
        end else if (hit_guard) begin
            rd_byte[psd_pkg::GUARD_BIT] = st_r.guard;
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        // read data is captured in the setup cycle, so a status bit
        // that moves during the access phase shows on the next read
        if (setup_phase) begin
            st_nxt.prdata = {24'h00_0000, rd_byte};
        end
        if (mult_wr) begin
            // reserved gain codes are kept as written
            st_nxt.mult = wdata;
        end
        if (reference_divisor_wr) begin
            st_nxt.reference_divisor = wdata & psd_pkg::REFERENCE_DIVISOR_MASK;
        end
        if (post_wr) begin
            st_nxt.post = wdata & psd_pkg::POST_MASK;
        end
        if (clks_wr) begin
            st_nxt.pll_sel = wdata[psd_pkg::CLKS_BUS_FROM_PLL_SELECT_BIT];
        end
        if (osc_wr) begin
            st_nxt.osc_en = wdata[psd_pkg::OSC_ENABLE_BIT];
        end
        if (guard_wr) begin
            st_nxt.guard = wdata[psd_pkg::GUARD_BIT];
        end
        // a change of settled wins over a same-cycle clear
        st_nxt.settled_prev = settled;
        if (settled != st_r.settled_prev) begin
            st_nxt.chg_flag = 1'b1;
        end else if (flags_wr && wdata[psd_pkg::FLG_CHANGE_BIT]) begin
            st_nxt.chg_flag = 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            st_r.mult <= psd_pkg::MULT_RST;
            st_r.reference_divisor <= psd_pkg::REFERENCE_DIVISOR_RST;
            st_r.post <= psd_pkg::POST_RST;
            st_r.pll_sel <= psd_pkg::CLKS_BUS_FROM_PLL_SELECT_RST;
            st_r.osc_en <= psd_pkg::OSC_ENABLE_RST;
            st_r.guard <= psd_pkg::GUARD_RST;
            st_r.chg_flag <= 1'b0;
            st_r.settled_prev <= 1'b0;
            st_r.prdata <= 32'h0000_0000;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // lock detector and oscillator qualifier
    // ------------------------------------------------------------
    // the loop is modelled as settling a fixed time after each
    // change of target; the divide-by-4 stays until then
    psd_settle_timer #(
        .CYCLES(LOCK_CYCLES)
    ) u_lock_timer (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .restart_in(lock_restart),
        .enable_in(1'b1),
        .done_out(settled)
    );

    // qualification rides on the vco, so losing lock loses it too
    psd_settle_timer #(
        .CYCLES(QUAL_CYCLES)
    ) u_qual_timer (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .restart_in(qual_restart),
        .enable_in(st_r.osc_en && settled),
        .done_out(qualified)
    );

    // ------------------------------------------------------------
    // frequency derivation
    // ------------------------------------------------------------
    psd_freq_calc u_freq (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .osc_freq_khz_in(osc_freq_khz_in),
        .osc_enable_in(st_r.osc_en),
        .ref_div_in(st_r.reference_divisor[psd_pkg::REF_DIV_LSB +: 4]),
        .mult_in(st_r.mult[psd_pkg::MULT_DIV_LSB +: 6]),
        .post_div_in(st_r.post[4:0]),
        .settled_in(settled),
        .pll_sel_in(st_r.pll_sel),
        .freq_out(freq_out)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign apb_prdata_out = st_r.prdata;
    // zero wait states: every access completes in its first cycle
    assign apb_pready_out = 1'b1;
    assign apb_pslverr_out = access_phase && !mapped;

    assign feedback_multiplier_out = st_r.mult[psd_pkg::MULT_DIV_LSB +: 6];
    assign vco_gain_range_out = st_r.mult[psd_pkg::MULT_GAIN_LSB +: 2];
    assign reference_divisor_out = st_r.reference_divisor[psd_pkg::REF_DIV_LSB +: 4];
    // the stored filter code is ignored on the internal reference
    assign loop_filter_range_out = st_r.osc_en ?
        st_r.reference_divisor[psd_pkg::REF_FILT_LSB +: 2] :
        psd_pkg::FIXED_FILTER;
    assign output_divisor_out = st_r.post[4:0];
    assign external_osc_enable_out = st_r.osc_en;
    assign bus_from_pll_select_out = st_r.pll_sel;

    assign pll_settled_out = settled;
    assign oscillator_qualified_out = qualified;
    assign settle_change_flag_out = st_r.chg_flag;

endmodule

// ### bench/psd_pll_synth_divider_control_monitor.sv
`timescale 1ns/10ps
module psd_pll_synth_divider_control_monitor #(
    parameter int unsigned LOCK_CYCLES = 8,
    parameter int unsigned QUAL_CYCLES = 4
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic reset_in,
    // apb and oscillator
    input wire psd_pkg::psd_apb_req_t apb_req_in,
    input wire logic [31:0] apb_prdata_out,
    input wire logic apb_pready_out,
    input wire logic apb_pslverr_out,
    input wire logic [31:0] osc_freq_khz_in,
    // settings and status
    input wire logic [5:0] feedback_multiplier_out,
    input wire logic [1:0] vco_gain_range_out,
    input wire logic [3:0] reference_divisor_out,
    input wire logic [1:0] loop_filter_range_out,
    input wire logic [4:0] output_divisor_out,
    input wire logic external_osc_enable_out,
    input wire logic bus_from_pll_select_out,
    input wire logic pll_settled_out,
    input wire logic oscillator_qualified_out,
    input wire logic settle_change_flag_out,
    input wire psd_pkg::psd_freq_t freq_out
);
    // ------------------------------------------------
    // helpers
    // ------------------------------------------------
    logic wr, wr_mult, wr_post;
    logic [31:0] mult_plus, div_plus, post_plus;
    logic [31:0] unl_cnt_r, unl_cnt_nxt;
    assign wr = apb_req_in.psel && apb_req_in.penable && apb_req_in.pwrite;
    assign wr_mult = wr && apb_req_in.paddr == 12'h0d0;
    assign wr_post = wr && apb_req_in.paddr == 12'h0d8;
    assign mult_plus = 32'(feedback_multiplier_out) + 32'h0000_0001;
    assign div_plus = 32'(reference_divisor_out) + 32'h0000_0001;
    assign post_plus = 32'(output_divisor_out) + 32'h0000_0001;
    // a timer restart while unlocked only makes this count larger
    always_comb begin
        unl_cnt_nxt = pll_settled_out ? 32'h0000_0000 :
            unl_cnt_r + 32'h0000_0001;
    end
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            unl_cnt_r <= 32'h0000_0000;
        end else begin
            unl_cnt_r <= unl_cnt_nxt;
        end
    end
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (reset_in);
    // ------------------------------------------------
    // assertions
    // ------------------------------------------------
    a_mult_refused: assert property (
        wr_mult && !bus_from_pll_select_out
        |=> $stable({vco_gain_range_out, feedback_multiplier_out}))
        else $error("multiplier changed while pll select low");
    a_mult_drops: assert property (
        $changed({vco_gain_range_out, feedback_multiplier_out})
        |-> !pll_settled_out && !oscillator_qualified_out)
        else $error("multiplier write kept lock status");
    a_reference_divisor_drops: assert property ($changed(reference_divisor_out)
        |-> !pll_settled_out && !oscillator_qualified_out)
        else $error("reference divider write kept lock status");
    a_vco_internal: assert property (!external_osc_enable_out
        |=> freq_out.vco_khz == 32'h0000_07d0 * $past(mult_plus))
        else $error("vco frequency wrong on internal reference");
    a_ref_external: assert property (external_osc_enable_out
        |=> freq_out.ref_khz == $past(osc_freq_khz_in) / $past(div_plus))
        else $error("reference frequency wrong on oscillator");
    a_post_taken: assert property (wr_post && bus_from_pll_select_out
        |=> output_divisor_out == $past(apb_req_in.pwdata[4:0]))
        else $error("post divider write not taken");
    a_pll_unlocked: assert property (!pll_settled_out
        |=> freq_out.pll_khz == (freq_out.vco_khz >> 2))
        else $error("unlocked output not vco over four");
    a_pll_locked: assert property (pll_settled_out
        |=> freq_out.pll_khz == freq_out.vco_khz / $past(post_plus))
        else $error("locked output not vco over post divider");
    a_bus_half: assert property (bus_from_pll_select_out
        |=> freq_out.bus_khz == (freq_out.pll_khz >> 1))
        else $error("bus frequency not half of output");
    a_flag_sets: assert property ($changed(pll_settled_out)
        |=> settle_change_flag_out)
        else $error("change flag not set on lock change");
    a_lock_wait: assert property ($rose(pll_settled_out)
        |-> unl_cnt_r >= 32'(LOCK_CYCLES))
        else $error("lock reported before lock time");
endmodule

bind psd_pll_synth_divider_control psd_pll_synth_divider_control_monitor #(
    .LOCK_CYCLES(LOCK_CYCLES),
    .QUAL_CYCLES(QUAL_CYCLES)
) u_monitor (
    .core_clk_in(core_clk_in), .reset_in(reset_in), .apb_req_in(apb_req_in),
    .apb_prdata_out(apb_prdata_out), .apb_pready_out(apb_pready_out),
    .apb_pslverr_out(apb_pslverr_out), .osc_freq_khz_in(osc_freq_khz_in),
    .feedback_multiplier_out(feedback_multiplier_out),
    .vco_gain_range_out(vco_gain_range_out),
    .reference_divisor_out(reference_divisor_out),
    .loop_filter_range_out(loop_filter_range_out),
    .output_divisor_out(output_divisor_out),
    .external_osc_enable_out(external_osc_enable_out),
    .bus_from_pll_select_out(bus_from_pll_select_out),
    .pll_settled_out(pll_settled_out),
    .oscillator_qualified_out(oscillator_qualified_out),
    .settle_change_flag_out(settle_change_flag_out), .freq_out(freq_out)
);

// ### bench/test_psd_pll_synth_divider_control.sv
`timescale 1ns/10ps
module test_psd_pll_synth_divider_control;
    // ------------------------------------------------
    // signals and model state
    // ------------------------------------------------
    logic core_clk_in = 1'b0;
    logic reset_in = 1'b1;
    psd_pkg::psd_apb_req_t req = '0;
    logic [31:0] osc_khz = 32'h0000_0000;
    logic [31:0] prdata, rd, x;
    logic pready, pslverr, err;
    logic [5:0] mult_o;
    logic [1:0] gain_o, filt_o;
    logic [3:0] div_o;
    logic [4:0] post_o;
    logic osc_o, sel_o, lock_o, qual_o, flag_o;
    psd_pkg::psd_freq_t freq;
    int num_errors = 0;
    int compares = 0;
    int seed = 58023;
    int m_mult = 8'h5f, m_ref = 0, m_post = 3, m_sel = 1, m_osc = 0, m_grd = 0;

    psd_pll_synth_divider_control #(
        .LOCK_CYCLES(8),
        .QUAL_CYCLES(4)
    ) dut (
        .core_clk_in(core_clk_in), .reset_in(reset_in), .apb_req_in(req),
        .apb_prdata_out(prdata), .apb_pready_out(pready),
        .apb_pslverr_out(pslverr), .osc_freq_khz_in(osc_khz),
        .feedback_multiplier_out(mult_o), .vco_gain_range_out(gain_o),
        .reference_divisor_out(div_o), .loop_filter_range_out(filt_o),
        .output_divisor_out(post_o), .external_osc_enable_out(osc_o),
        .bus_from_pll_select_out(sel_o), .pll_settled_out(lock_o),
        .oscillator_qualified_out(qual_o), .settle_change_flag_out(flag_o),
        .freq_out(freq)
    );

    always #5 core_clk_in = ~core_clk_in;

    // ------------------------------------------------
    // tasks
    // ------------------------------------------------
    task automatic check(input string w, input logic [31:0] e,
                         input logic [31:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", w, e, g);
        end
    endtask

    function automatic void model_write(input logic [9:0] i, input int d);
        case (i)
            psd_pkg::IDX_MULT:
                if (!m_grd && m_sel) m_mult = d & 8'hff;
            psd_pkg::IDX_REFERENCE_DIVISOR:
                if (!m_grd && m_sel) m_ref = d & 8'hcf;
            psd_pkg::IDX_POST: if (m_sel) m_post = d & 8'h1f;
            psd_pkg::IDX_CLKS: if (!m_grd) m_sel = (d >> 7) & 1;
            psd_pkg::IDX_OSC: if (!m_grd) m_osc = (d >> 7) & 1;
            psd_pkg::IDX_GUARD: m_grd = d & 1;
            default: ;
        endcase
    endfunction

    // one apb transfer; the slave's pready decides when it ends
    task automatic apb(input logic w, input logic [9:0] i,
                       input logic [31:0] d);
        @(posedge core_clk_in);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {i, 2'b00},
                 pwdata: d};
        @(posedge core_clk_in);
        req.penable <= 1'b1;
        @(posedge core_clk_in);
        while (pready !== 1'b1) @(posedge core_clk_in);
        rd = prdata;
        err = pslverr;
        req <= '0;
        if (w) model_write(i, d);
    endtask

    task automatic wait_lock();
        do @(negedge core_clk_in); while (lock_o !== 1'b1);
    endtask

    task automatic check_regs();
        apb(1'b0, psd_pkg::IDX_MULT, '0);
        check("mult", m_mult, rd);
        apb(1'b0, psd_pkg::IDX_REFERENCE_DIVISOR, '0);
        check("reference_divisor", m_ref, rd);
        apb(1'b0, psd_pkg::IDX_POST, '0);
        check("post", m_post, rd);
        apb(1'b0, psd_pkg::IDX_CLKS, '0);
        check("clks", m_sel * 128, rd);
        apb(1'b0, psd_pkg::IDX_OSC, '0);
        check("osc", m_osc * 128, rd);
        apb(1'b0, psd_pkg::IDX_GUARD, '0);
        check("guard", m_grd, rd);
    endtask

    // waits for lock so that the expected output divider is certain
    task automatic check_freq();
        int r, v, p;
        wait_lock();
        repeat (2) @(negedge core_clk_in);
        r = m_osc ? osc_khz / ((m_ref & 15) + 1) : 32'h0000_03e8;
        v = 2 * r * ((m_mult & 63) + 1);
        p = v / (m_post + 1);
        check("ref", r, freq.ref_khz);
        check("vco", v, freq.vco_khz);
        check("pll", p, freq.pll_khz);
        check("bus", m_sel ? p / 2 : osc_khz, freq.bus_khz);
        check("filter", m_osc ? m_ref / 64 : 0, filt_o);
        check("fields", {m_mult[7:0], m_ref[3:0], m_post[4:0], m_osc[0],
              m_sel[0]},
              {gain_o, mult_o, div_o, post_o, osc_o, sel_o});
    endtask

    task automatic tally_and_finish();
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------------------------
    // sequence
    // ------------------------------------------------
    initial begin
        repeat (2) @(posedge core_clk_in);
        reset_in <= 1'b0;
        x = $random(seed);
        osc_khz <= (32'(x[2:0]) + 32'h0000_0001) * 32'h0000_0fa0;
        check_freq();
        check_regs();
        @(negedge core_clk_in);
        check("flag", 1, flag_o);
        apb(1'b0, 10'h038, '0);
        check("slverr", 1, err);
        check("unmapped", 0, rd);
        for (int g = 0; g < 4; g++) begin
            x = $random(seed);
            apb(1'b1, psd_pkg::IDX_MULT, {24'h00_0000, g[1:0], x[5:0]});
            @(negedge core_clk_in);
            check("drop", 0, {lock_o, qual_o});
            check_freq();
            apb(1'b1, psd_pkg::IDX_FLAGS, 32'h0000_0010);
            apb(1'b0, psd_pkg::IDX_FLAGS, '0);
            check("flags", 8, rd);
        end
        apb(1'b1, psd_pkg::IDX_GUARD, 32'h0000_0001);
        apb(1'b1, psd_pkg::IDX_MULT, 32'h0000_0041);
        apb(1'b1, psd_pkg::IDX_REFERENCE_DIVISOR, 32'h0000_0042);
        apb(1'b1, psd_pkg::IDX_CLKS, 32'h0000_0000);
        apb(1'b1, psd_pkg::IDX_POST, 32'h0000_0001);
        @(negedge core_clk_in);
        check("held", 1, lock_o);
        check_freq();
        apb(1'b1, psd_pkg::IDX_GUARD, 32'h0000_0000);
        apb(1'b1, psd_pkg::IDX_CLKS, 32'h0000_0000);
        apb(1'b1, psd_pkg::IDX_MULT, 32'h0000_0017);
        apb(1'b1, psd_pkg::IDX_POST, 32'h0000_0007);
        check_regs();
        check_freq();
        apb(1'b1, psd_pkg::IDX_CLKS, 32'h0000_0080);
        apb(1'b1, psd_pkg::IDX_REFERENCE_DIVISOR, 32'h0000_00ff);
        check_regs();
        apb(1'b1, psd_pkg::IDX_REFERENCE_DIVISOR, 32'h0000_0083);
        check_freq();
        apb(1'b1, psd_pkg::IDX_OSC, 32'h0000_0080);
        wait_lock();
        repeat (6) @(negedge core_clk_in);
        check("qualified", 1, qual_o);
        check_freq();
        apb(1'b1, psd_pkg::IDX_REFERENCE_DIVISOR, 32'h0000_0041);
        @(negedge core_clk_in);
        check("drop", 0, {lock_o, qual_o});
        check_freq();
        apb(1'b1, psd_pkg::IDX_OSC, 32'h0000_0000);
        check_freq();
        tally_and_finish();
    end

    initial begin
        repeat (20000) @(posedge core_clk_in);
        num_errors++;
        tally_and_finish();
    end
endmodule
